/* File: rtl/dac_host_pkg.sv */
// Constants for the host-side controller of the nibble-latch converter
// Notes on behaviour
// RULE1 - Device clears its output latch at power-up
// RULE2 - Clear low forces output latch to zero
// RULE3 - Clear acts asynchronously, ignores device select
// RULE4 - Host may hold clear low to save power
// RULE5 - Host writes all twelve bits every word
// RULE6 - Host writes zeros into both sub-LSBs
// RULE7 - Word splits into low, mid, high nibbles
// RULE8 - Latch choice from address, strobe, select only
// RULE9 - Address pairs select high, mid or low nibble
// RULE10 - Both address low loads eight bits, no update
// RULE11 - Output latch updates all twelve bits together
// RULE12 - Output latch captures on load rising edge
// RULE13 - Load low near strobe rise: hold 50ns
// RULE14 - Load held low makes output latch transparent
// RULE15 - Four-bit host ties low and mid pins
// RULE16 - Four-bit host writes three nibble cycles
// RULE17 - Eight-bit host drives sub-LSBs and D0-D5
// RULE18 - With load high, parts in either order
// RULE19 - Fast mode ties address lines, two cycles
// RULE20 - Transparent mode writes eight-bit part first
// RULE21 - Load low moves input latch to output
// RULE22 - Device select gates all addressing and writing
// RULE23 - Latches hold while select or strobe high
// RULE24 - Selected nibble follows pins, holds at strobe rise
package dac_host_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETUP_NS = 20;
	localparam int STROBE_NS = 50;
	localparam int HOLD_NS = 20;
	localparam int LOAD_NS = 50;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_CYC = (LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [1:0] SEL_LOWMID = 2'h0;
	localparam logic [1:0] SEL_MID = 2'h1;
	localparam logic [1:0] SEL_LOW = 2'h2;
	localparam logic [1:0] SEL_HIGH = 2'h3;
	localparam logic [1:0] MODE_NIBBLE = 2'h0;
	localparam logic [1:0] MODE_BYTE = 2'h1;
	localparam logic [1:0] MODE_FAST = 2'h2;
	localparam logic [7:0] BUS_RESET = 8'h00;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_STROBE = 3'h2,
		ST_HOLD = 3'h3,
		ST_LOAD = 3'h4
	} state_t;
endpackage : dac_host_pkg

/* File: rtl/dac_word_store.sv */
// Holds the last accepted 10-bit word with a registered read port
`timescale 1ns/10ps
module dac_word_store (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_we,
	input wire logic [9:0] i_wdata,
	output logic [9:0] o_rdata
);
	logic [9:0] mem_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			mem_r <= 10'h000;
		end else if (i_we) begin
			mem_r <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 10'h000;
		end else begin
			o_rdata <= mem_r;
		end
	end
endmodule : dac_word_store

/* File: rtl/dac_nibble_host.sv */
// Host controller writing 10-bit words into the nibble-latch converter
`timescale 1ns/10ps
module dac_nibble_host (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic I_START,
	input wire logic [9:0] I_WORD,
	input wire logic [1:0] I_MODE,
	input wire logic I_SHUTDOWN,
	output logic O_BUSY,
	output logic O_DONE,
	output logic [7:0] O_DATA,
	output logic O_NIBBLE_SEL_0,
	output logic O_NIBBLE_SEL_1,
	output logic O_DEVICE_SELECT_N,
	output logic O_WRITE_STROBE_N,
	output logic O_LOAD_OUTPUT_N,
	output logic O_CLEAR_N
);
	dac_host_pkg::state_t state_r;
	logic [dac_host_pkg::CNT_W-1:0] cnt_r;
	logic [1:0] step_r;
	logic [1:0] nsteps_r;
	logic [1:0] mode_r;
	logic [9:0] stored;
	logic [1:0] cur_sel;
	logic load_now;
	logic take;
	logic bus_cycle;
	logic sel_window;

	// True in the last cycle of a phase that lasts n cycles
	function automatic logic last_count(input logic [dac_host_pkg::CNT_W-1:0] c,
		input int n);
		last_count = (int'(c) == n - 1);
	endfunction : last_count

	// True while a write step owns the bus pins
	function automatic logic in_bus_state(input dac_host_pkg::state_t s);
		in_bus_state = (s == dac_host_pkg::ST_SETUP) || (s == dac_host_pkg::ST_STROBE) ||
			(s == dac_host_pkg::ST_HOLD);
	endfunction : in_bus_state

	// Word padded with two zero sub-LSBs below the ten data bits
	function automatic logic [11:0] pad_word(input logic [9:0] w);
		pad_word = {w, 2'b00}; // see RULE5, see RULE6
	endfunction : pad_word

	// Address pair and bus byte for one step of a transfer
	function automatic logic [1:0] step_sel(input logic [1:0] m, input logic [1:0] s);
		if (m == dac_host_pkg::MODE_NIBBLE) begin
			case (s)
				2'h0: step_sel = dac_host_pkg::SEL_LOW;
				2'h1: step_sel = dac_host_pkg::SEL_MID;
				default: step_sel = dac_host_pkg::SEL_HIGH;
			endcase
		end else begin
			step_sel = (s == 2'h0) ? dac_host_pkg::SEL_LOWMID : dac_host_pkg::SEL_HIGH;
		end
	endfunction : step_sel

	function automatic logic [7:0] step_data(input logic [1:0] m, input logic [1:0] s,
		input logic [11:0] w);
		logic [1:0] sel;
		sel = step_sel(m, s);
		case (sel)
			dac_host_pkg::SEL_LOW: step_data = {w[3:0], w[3:0]}; // see RULE15, see RULE7
			dac_host_pkg::SEL_MID: step_data = {w[7:4], w[7:4]};
			dac_host_pkg::SEL_HIGH: step_data = {w[11:8], w[11:8]};
			default: step_data = w[7:0]; // see RULE17
		endcase
	endfunction : step_data

	assign take = I_START && (state_r == dac_host_pkg::ST_IDLE) && !I_SHUTDOWN;

	// Address pair of the current step, one bit to each address pin
	assign cur_sel = step_sel(mode_r, step_r);

	// Select stays high in the first setup cycle of every step, so address and data
	// change only with select high and each step gets a write cycle of its own
	assign bus_cycle = in_bus_state(state_r);
	assign sel_window = bus_cycle && !(state_r == dac_host_pkg::ST_SETUP && cnt_r == '0);

	dac_word_store u_store (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_we(take),
		.i_wdata(I_WORD),
		.o_rdata(stored)
	);

	// Sequencer
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			state_r <= dac_host_pkg::ST_IDLE;
			cnt_r <= '0;
			step_r <= 2'h0;
		end else begin
			case (state_r)
				dac_host_pkg::ST_IDLE: begin
					// A start is refused while busy or in shutdown
					if (take) begin
						state_r <= dac_host_pkg::ST_SETUP;
						cnt_r <= '0;
						step_r <= 2'h0;
					end
				end
				dac_host_pkg::ST_SETUP: begin
					if (last_count(cnt_r, dac_host_pkg::SETUP_CYC)) begin
						state_r <= dac_host_pkg::ST_STROBE;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				dac_host_pkg::ST_STROBE: begin
					if (last_count(cnt_r, dac_host_pkg::STROBE_CYC)) begin
						state_r <= dac_host_pkg::ST_HOLD;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				dac_host_pkg::ST_HOLD: begin
					if (last_count(cnt_r, dac_host_pkg::HOLD_CYC)) begin
						cnt_r <= '0;
						if (step_r == nsteps_r - 2'h1) begin
							// Fast mode already keeps load low; it still ends with a pulse
							state_r <= dac_host_pkg::ST_LOAD;
						end else begin
							step_r <= step_r + 2'h1; // see RULE16, see RULE18
							state_r <= dac_host_pkg::ST_SETUP;
						end
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				dac_host_pkg::ST_LOAD: begin
					if (last_count(cnt_r, dac_host_pkg::LOAD_CYC)) begin
						state_r <= dac_host_pkg::ST_IDLE; // see RULE13
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= dac_host_pkg::ST_IDLE;
					cnt_r <= '0;
				end
			endcase
		end
	end

	// Transfer parameters captured at start
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			mode_r <= dac_host_pkg::MODE_NIBBLE;
			nsteps_r <= 2'h3;
		end else if (take) begin
			mode_r <= I_MODE;
			nsteps_r <= (I_MODE == dac_host_pkg::MODE_NIBBLE) ? 2'h3 : 2'h2; // see RULE19
		end
	end

	// Load low in the pulse state, or throughout a fast-mode transfer
	assign load_now = (state_r == dac_host_pkg::ST_LOAD) ||
		(mode_r == dac_host_pkg::MODE_FAST && state_r != dac_host_pkg::ST_IDLE); // see RULE14

	// Bus pins
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			O_DATA <= dac_host_pkg::BUS_RESET;
			O_NIBBLE_SEL_0 <= 1'b0;
			O_NIBBLE_SEL_1 <= 1'b0;
			O_DEVICE_SELECT_N <= 1'b1;
			O_WRITE_STROBE_N <= 1'b1;
			O_LOAD_OUTPUT_N <= 1'b1;
		end else begin
			if (bus_cycle) begin
				// The first setup cycle may still show the previous stored word,
				// harmless because select is high then
				O_DATA <= step_data(mode_r, step_r, pad_word(stored));
				// Fast mode puts low/mid first, high last
				O_NIBBLE_SEL_0 <= cur_sel[0]; // see RULE9, see RULE20
				O_NIBBLE_SEL_1 <= cur_sel[1]; // see RULE10
			end
			O_DEVICE_SELECT_N <= !sel_window; // see RULE16
			O_WRITE_STROBE_N <= (state_r != dac_host_pkg::ST_STROBE); // see RULE8
			O_LOAD_OUTPUT_N <= !load_now; // see RULE12
		end
	end

	// Clear pin doubles as shutdown control
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			// Held low through reset so the converter output starts at zero
			O_CLEAR_N <= 1'b0;
		end else begin
			O_CLEAR_N <= !I_SHUTDOWN; // see RULE4
		end
	end

	// Busy mirrors a non-idle sequencer, so a start seen with busy low is taken unless shutdown is high
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			O_BUSY <= 1'b0;
		end else begin
			O_BUSY <= take || (state_r != dac_host_pkg::ST_IDLE &&
				!(state_r == dac_host_pkg::ST_LOAD &&
				last_count(cnt_r, dac_host_pkg::LOAD_CYC)));
		end
	end

	// Done marks the last load cycle; load returns high on the following edge
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			O_DONE <= 1'b0;
		end else begin
			O_DONE <= (state_r == dac_host_pkg::ST_LOAD) &&
				last_count(cnt_r, dac_host_pkg::LOAD_CYC);
		end
	end
endmodule : dac_nibble_host

/* File: bench/dac_host_chk_sva.sv */
// Checker for the host-side nibble-latch controller
`timescale 1ns/10ps
module dac_host_chk (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic I_START,
	input wire logic I_SHUTDOWN,
	input wire logic O_BUSY,
	input wire logic O_DONE,
	input wire logic [7:0] O_DATA,
	input wire logic O_NIBBLE_SEL_0,
	input wire logic O_NIBBLE_SEL_1,
	input wire logic O_DEVICE_SELECT_N,
	input wire logic O_WRITE_STROBE_N,
	input wire logic O_LOAD_OUTPUT_N,
	input wire logic O_CLEAR_N
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	wire logic [1:0] sel = {O_NIBBLE_SEL_1, O_NIBBLE_SEL_0};
	a_sub_lsb_zero: assert property (
		!O_WRITE_STROBE_N && !sel[0] |-> O_DATA[1:0] == 2'h0)
		else $error("sub-LSB bits not zero");
	a_clear_follows: assert property (I_SHUTDOWN |=> !O_CLEAR_N)
		else $error("clear not driven in shutdown");
	a_strobe_width: assert property ($fell(O_WRITE_STROBE_N) |->
		(!O_WRITE_STROBE_N) [*5] ##1 O_WRITE_STROBE_N)
		else $error("strobe width wrong");
	a_strobe_gated: assert property (!O_WRITE_STROBE_N |-> !O_DEVICE_SELECT_N)
		else $error("strobe outside select");
	a_addr_steady: assert property (!O_DEVICE_SELECT_N && $past(!O_DEVICE_SELECT_N) |->
		$stable({O_DATA, sel}))
		else $error("address or data moved in select");
	a_load_width: assert property ($fell(O_LOAD_OUTPUT_N) |-> (!O_LOAD_OUTPUT_N) [*5])
		else $error("load pulse too short");
	a_done_after_load: assert property ($rose(O_LOAD_OUTPUT_N) |-> $fell(O_DONE))
		else $error("done pulse not just before load rise");
	a_start_taken: assert property (
		I_START && !O_BUSY && !O_DONE && !I_SHUTDOWN && O_CLEAR_N |=> O_BUSY)
		else $error("start not taken");
	cover property ($fell(O_LOAD_OUTPUT_N));
	cover property (!O_WRITE_STROBE_N && sel == 2'h0);
	cover property (!O_CLEAR_N && I_SHUTDOWN);
endmodule : dac_host_chk

bind dac_nibble_host dac_host_chk u_chk (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_START(I_START),
	.I_SHUTDOWN(I_SHUTDOWN), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_DATA(O_DATA),
	.O_NIBBLE_SEL_0(O_NIBBLE_SEL_0), .O_NIBBLE_SEL_1(O_NIBBLE_SEL_1),
	.O_DEVICE_SELECT_N(O_DEVICE_SELECT_N), .O_WRITE_STROBE_N(O_WRITE_STROBE_N),
	.O_LOAD_OUTPUT_N(O_LOAD_OUTPUT_N), .O_CLEAR_N(O_CLEAR_N));

/* File: bench/dac_latch_model.sv */
// Behavioural model of the converter's input and output latches
`timescale 1ns/10ps
module dac_latch_model (
	input wire logic [7:0] i_data,
	input wire logic [1:0] i_sel,
	input wire logic i_device_select_n,
	input wire logic i_write_strobe_n,
	input wire logic i_load_output_n,
	input wire logic i_clear_n,
	output logic [11:0] o_level
);
	logic [3:0] low_r;
	logic [3:0] mid_r;
	logic [3:0] high_r;
	// Converter latch starts cleared, as after power-up
	logic [11:0] dac_r = 12'h000;
	wire logic wr = !i_device_select_n && !i_write_strobe_n;
	always @* if (wr && !i_sel[0]) low_r = i_data[3:0];
	always @* if (wr && !i_sel[1]) mid_r = i_data[7:4];
	// High nibble shares its pins with the low nibble pins
	always @* if (wr && i_sel == 2'h3) high_r = i_data[3:0];
	always @* begin
		if (!i_clear_n)
			dac_r = 12'h000;
		else if (!i_load_output_n && !(wr && i_sel == 2'h0))
			dac_r = {high_r, mid_r, low_r};
	end
	assign o_level = dac_r;
endmodule : dac_latch_model

/* File: bench/tb.sv */
// Self-checking bench for the nibble-latch host controller
`timescale 1ns/10ps
module tb;
	logic I_MCLK = 1'b0;
	logic I_RST_N = 1'b0;
	logic I_START = 1'b0;
	logic I_SHUTDOWN = 1'b0;
	logic [9:0] I_WORD = 10'h000;
	logic [1:0] I_MODE = 2'h0;
	logic O_BUSY, O_DONE, sel_0, sel_1, cs_n, wr_n, ld_n, clr_n;
	logic [7:0] bus;
	logic [11:0] level;
	int err_count = 0;
	int num_checks = 0;
	always #5 I_MCLK = ~I_MCLK;
	dac_nibble_host DUT (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_START(I_START), .I_WORD(I_WORD),
		.I_MODE(I_MODE), .I_SHUTDOWN(I_SHUTDOWN), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_DATA(bus),
		.O_NIBBLE_SEL_0(sel_0), .O_NIBBLE_SEL_1(sel_1), .O_DEVICE_SELECT_N(cs_n),
		.O_WRITE_STROBE_N(wr_n), .O_LOAD_OUTPUT_N(ld_n), .O_CLEAR_N(clr_n));
	dac_latch_model u_dev (.i_data(bus), .i_sel({sel_1, sel_0}), .i_device_select_n(cs_n),
		.i_write_strobe_n(wr_n), .i_load_output_n(ld_n), .i_clear_n(clr_n), .o_level(level));
	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge I_MCLK);
		#1;
	endtask : tick
	task automatic go(input logic [1:0] mode, input logic [9:0] w);
		I_START = 1'b1;
		I_MODE = mode;
		I_WORD = w;
		tick(1);
		I_START = 1'b0;
	endtask : go
	task automatic wait_done;
		for (int i = 0; i < 200 && O_DONE !== 1'b1; i++) tick(1);
		chk("done", {11'h000, O_DONE}, 12'h001);
		tick(1);
	endtask : wait_done
	task automatic t_modes;
		logic [9:0] words [4] = '{10'h155, 10'h2AA, 10'h001, 10'h3FF};
		for (int m = 0; m < 4; m++) begin
			go(m[1:0], words[m]);
			wait_done();
			chk("level", level, {words[m], 2'h0});
		end
	endtask : t_modes
	task automatic t_hold;
		go(dac_host_pkg::MODE_BYTE, 10'h2C3);
		for (int i = 0; i < 100 && ld_n !== 1'b0; i++) begin
			chk("held", level, 12'hFFC);
			tick(1);
		end
		wait_done();
		chk("loaded", level, 12'hB0C);
	endtask : t_hold
	task automatic t_shutdown;
		I_SHUTDOWN = 1'b1;
		tick(2);
		chk("cleared", level, 12'h000);
		go(dac_host_pkg::MODE_NIBBLE, 10'h0F0);
		tick(1);
		chk("refused", {11'h000, O_BUSY}, 12'h000);
		I_SHUTDOWN = 1'b0;
		tick(2);
		go(dac_host_pkg::MODE_FAST, 10'h0F0);
		wait_done();
		chk("fast", level, 12'h3C0);
	endtask : t_shutdown
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		tick(10);
		I_RST_N = 1'b1;
		tick(1);
		chk("por", level, 12'h000);
		t_modes();
		t_hold();
		t_shutdown();
		complete_run();
	end
	initial begin
		#100000;
		err_count++;
		complete_run();
	end
endmodule : tb
